// file: tos_tx_overhead_select.sv
// e1 transmit overhead selector: registers, ts0 overhead builder, frame sync pins
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tos_regs.svh"
// Contract
// - e-bit source 00 sends each e-bit as 0 for every errored received sub-multiframe, with at most 3 pending, else 1.
// - e-bit source 01 forces every outgoing e-bit to 0.
// - e-bit source 11 fills the e-bit positions with data-link bits from the serial input.
// - the e-bit source only acts while the framing pattern source bit is 0.
// - under system control a sampled-high frame sync input starts a new frame.
// - with clock source 01, sync select 0 makes both sync pins inputs and 1 makes them outputs.
// - framing pattern source 0 builds alignment, multiframe, e and a bits inside, 1 takes serial.
module tos_tx_overhead_select (
  // system clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite register slave
  input  wire logic [`TOS_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`TOS_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // receive framer feedback, one pulse per errored sub-multiframe
  input  wire logic                   rx_smf_crc_err,
  // transmit link, on the transmit serial clock
  input  wire logic                   tx_serial_clock,
  input  wire logic                   tx_serial_input_ch,
  input  wire logic                   tx_frame_boundary_pin_i,
  output logic                        tx_frame_boundary_pin_o,
  output logic                        tx_frame_boundary_pin_oe_n,
  input  wire logic                   tx_multiframe_boundary_pin_i,
  output logic                        tx_multiframe_boundary_pin_o,
  output logic                        tx_multiframe_boundary_pin_oe_n,
  output logic                        tx_line_data
);
  import tos_pkg::*;

  function automatic logic reg_hit(input logic [`TOS_AXI_AW-1:0] a);
    reg_hit = (a == `TOS_OFF_SMR) || (a == `TOS_OFF_CSS) ||
              (a == `TOS_OFF_STAT) || (a == `TOS_OFF_MFCNT);
  endfunction : reg_hit

  function automatic logic is_ebit(input tos_pos_type p);
    is_ebit = (p.bit_no == `TOS_TS0_SI) &&
              (p.frame == `TOS_EBIT_FRAME_A || p.frame == `TOS_EBIT_FRAME_B);
  endfunction : is_ebit

  function automatic logic is_ts0(input tos_pos_type p);
    is_ts0 = (p.bit_no[7:3] == `TOS_TS0_SLOT);
  endfunction : is_ts0

  function automatic logic [3:0] crc4_step(input logic [3:0] c, input logic din);
    logic fb;
    fb = c[3] ^ din;
    crc4_step = {c[2], c[1], c[0] ^ fb, fb};
  endfunction : crc4_step

  // one ts0 bit of the outbound frame
  function automatic logic ts0_bit(input tos_pos_type p, input tos_smr_type c,
                                   input logic ser, input logic [3:0] hold,
                                   input logic [1:0] pend);
    logic [6:0] faw;
    logic [5:0] mfaw;
    logic [2:0] k;
    logic       v;
    faw  = `TOS_FAW;
    mfaw = `TOS_MFAW;
    k    = p.bit_no[2:0];
    v    = ser;
    if (!c.fas_src) begin
      if (!p.frame[0]) begin
        if (k != 3'h0)
          v = faw[3'h7 - k];
        else if (!c.crc_src)
          v = hold[2'h3 - p.frame[2:1]];
      end else if (k == 3'h0) begin
        if (is_ebit(p)) begin
          case (c.ebit_src)
            `TOS_EBIT_CRC:  v = (pend == 2'h0);
            `TOS_EBIT_ZERO: v = 1'b0;
            `TOS_EBIT_ONE:  v = 1'b1;
            default:        v = ser;
          endcase
        end else begin
          v = mfaw[3'h5 - p.frame[3:1]];
        end
      end else if (k == 3'h1) begin
        v = 1'b1;
      end else if (k == 3'h2) begin
        v = `TOS_A_BIT;
      end
    end
    ts0_bit = v;
  endfunction : ts0_bit

  // ---------------- aclk domain ----------------
  logic                   reg_wr, reg_rok;
  logic [`TOS_AXI_AW-1:0] reg_waddr, reg_raddr;
  logic [31:0]            reg_wdata, reg_rdata;
  logic [3:0]             reg_wstrb;
  tos_smr_type            smr_r, smr_nxt;
  logic [1:0]             css_r, css_nxt;
  logic                   err_tgl_r, err_tgl_nxt, mf_seen_r, mf_seen_nxt;
  logic [15:0]            mf_cnt_r, mf_cnt_nxt;
  logic [2:0]             stat_a;

  tos_axil_slave #(.AW(`TOS_AXI_AW)) u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .reg_wr        (reg_wr),
    .reg_waddr     (reg_waddr),
    .reg_wdata     (reg_wdata),
    .reg_wstrb     (reg_wstrb),
    .reg_wok       (reg_hit(reg_waddr)),
    .reg_raddr     (reg_raddr),
    .reg_rdata     (reg_rdata),
    .reg_rok       (reg_rok)
  );

  assign reg_rok = reg_hit(reg_raddr);

  always_comb begin
    reg_rdata = 32'h0000_0000;
    case (reg_raddr)
      `TOS_OFF_SMR:   reg_rdata[7:0]  = smr_r;
      `TOS_OFF_CSS:   reg_rdata[1:0]  = css_r;
      `TOS_OFF_STAT:  reg_rdata[2:0]  = {stat_a[2:1] == LS_SLAVED, stat_a[2:1]};
      `TOS_OFF_MFCNT: reg_rdata[15:0] = mf_cnt_r;
      default:        reg_rdata = 32'h0000_0000;
    endcase
  end

  // receive errors travel as a toggle so no pulse is lost across clocks
  always_comb begin
    smr_nxt     = smr_r;
    css_nxt     = css_r;
    err_tgl_nxt = err_tgl_r ^ rx_smf_crc_err;
    mf_seen_nxt = stat_a[0];
    mf_cnt_nxt  = mf_cnt_r + {15'h0000, stat_a[0] ^ mf_seen_r};
    if (reg_wr && reg_wstrb[0]) begin
      if (reg_waddr == `TOS_OFF_SMR)
        smr_nxt = reg_wdata[7:0] & `TOS_SMR_WMASK;
      if (reg_waddr == `TOS_OFF_CSS)
        css_nxt = reg_wdata[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smr_r     <= `TOS_SMR_RST;
      css_r     <= `TOS_CSS_RST;
      err_tgl_r <= 1'b0;
      mf_seen_r <= 1'b0;
      mf_cnt_r  <= 16'h0000;
    end else begin
      smr_r     <= smr_nxt;
      css_r     <= css_nxt;
      err_tgl_r <= err_tgl_nxt;
      mf_seen_r <= mf_seen_nxt;
      mf_cnt_r  <= mf_cnt_nxt;
    end
  end

  // ---------------- link domain ----------------
  logic         lrst_n;
  tos_xcfg_type cfg_l;
  logic [2:0]   pins_s;
  logic         ser_s, fr_s, mf_s, ext_l;
  tos_ls_type   st_r, st_nxt;
  tos_pos_type  pos_r, pos_nxt;
  logic         data_r, data_nxt, fr_o_r, fr_o_nxt, mf_o_r, mf_o_nxt;
  logic         oe_n_r, oe_n_nxt, err_d_r, mf_tgl_r, mf_tgl_nxt;
  logic [1:0]   pend_r, pend_nxt;
  logic [3:0]   crc_r, crc_nxt, hold_r, hold_nxt;
  logic         inc, dec;

  // quasi-static configuration: settle it before relying on new values
  tos_sync_bus #(.W(1)) u_rst_sync (
    .clk (tx_serial_clock), .rst_n (1'b1), .d (aresetn), .q (lrst_n)
  );
  tos_sync_bus #(.W($bits(tos_xcfg_type))) u_cfg_sync (
    .clk (tx_serial_clock), .rst_n (lrst_n), .d ({err_tgl_r, css_r, smr_r}), .q (cfg_l)
  );
  tos_sync_bus #(.W(3)) u_pin_sync (
    .clk   (tx_serial_clock),
    .rst_n (lrst_n),
    .d     ({tx_serial_input_ch, tx_frame_boundary_pin_i, tx_multiframe_boundary_pin_i}),
    .q     (pins_s)
  );
  tos_sync_bus #(.W(3)) u_stat_sync (
    .clk (aclk), .rst_n (aresetn), .d ({st_r, mf_tgl_r}), .q (stat_a)
  );

  assign {ser_s, fr_s, mf_s} = pins_s;
  assign ext_l = (cfg_l.tx_clock_source_field == `TOS_CSS_TX_SERIAL_CLOCK) && !cfg_l.transmit_sync_mux_control.sync_sel;
  assign inc   = cfg_l.err_tgl ^ err_d_r;

  always_comb begin
    case (st_r)
      LS_IDLE:   st_nxt = ext_l ? LS_SLAVED : LS_FREE;
      LS_FREE:   st_nxt = ext_l ? LS_SLAVED : LS_FREE;
      LS_SLAVED: st_nxt = ext_l ? LS_SLAVED : LS_FREE;
      default:   st_nxt = LS_IDLE;
    endcase
    pos_nxt.bit_no = pos_r.bit_no + 8'h01;
    pos_nxt.frame  = pos_r.frame + {3'h0, pos_r.bit_no == `TOS_LAST_BIT};
    if (ext_l && mf_s) begin
      pos_nxt = '0;
    end else if (ext_l && fr_s) begin
      pos_nxt.bit_no = `TOS_TS0_SI;
      pos_nxt.frame  = pos_r.frame + 4'h1;
    end
    data_nxt = ser_s;
    if (is_ts0(pos_nxt))
      data_nxt = ts0_bit(pos_nxt, cfg_l.transmit_sync_mux_control, ser_s, hold_r, pend_r);
    // neither wins: an error arriving as one is consumed leaves the count unchanged
    dec = is_ebit(pos_nxt) && !cfg_l.transmit_sync_mux_control.fas_src &&
          (cfg_l.transmit_sync_mux_control.ebit_src == `TOS_EBIT_CRC) && (pend_r != 2'h0);
    pend_nxt = pend_r;
    if (inc && !dec && pend_r != `TOS_PEND_MAX)
      pend_nxt = pend_r + 2'h1;
    else if (dec && !inc)
      pend_nxt = pend_r - 2'h1;
    // crc over each sub-multiframe with its own check-bit slots taken as zero
    crc_nxt  = crc4_step(crc_r, (pos_nxt.bit_no == `TOS_TS0_SI && !pos_nxt.frame[0]) ?
                                1'b0 : data_nxt);
    hold_nxt = hold_r;
    if (pos_nxt.bit_no == `TOS_LAST_BIT && pos_nxt.frame[2:0] == `TOS_SMF_LAST) begin
      hold_nxt = crc_nxt;
      crc_nxt  = 4'h0;
    end
    fr_o_nxt   = (pos_nxt.bit_no == `TOS_TS0_SI);
    mf_o_nxt   = fr_o_nxt && (pos_nxt.frame == 4'h0);
    oe_n_nxt   = ext_l;
    mf_tgl_nxt = mf_tgl_r ^ mf_o_nxt;
  end

  always_ff @(posedge tx_serial_clock) begin
    if (!lrst_n) begin
      st_r     <= LS_IDLE;
      pos_r    <= '0;
      data_r   <= 1'b1;
      fr_o_r   <= 1'b0;
      mf_o_r   <= 1'b0;
      oe_n_r   <= 1'b1;
      err_d_r  <= 1'b0;
      mf_tgl_r <= 1'b0;
      pend_r   <= 2'h0;
      crc_r    <= 4'h0;
      hold_r   <= 4'h0;
    end else begin
      st_r     <= st_nxt;
      pos_r    <= pos_nxt;
      data_r   <= data_nxt;
      fr_o_r   <= fr_o_nxt;
      mf_o_r   <= mf_o_nxt;
      oe_n_r   <= oe_n_nxt;
      err_d_r  <= cfg_l.err_tgl;
      mf_tgl_r <= mf_tgl_nxt;
      pend_r   <= pend_nxt;
      crc_r    <= crc_nxt;
      hold_r   <= hold_nxt;
    end
  end

  assign tx_line_data                    = data_r;
  assign tx_frame_boundary_pin_o         = fr_o_r;
  assign tx_multiframe_boundary_pin_o    = mf_o_r;
  assign tx_frame_boundary_pin_oe_n      = oe_n_r;
  assign tx_multiframe_boundary_pin_oe_n = oe_n_r;

  // ---------------- checks ----------------
  chk_ebit_crc_err: assert property (@(posedge tx_serial_clock) disable iff (!lrst_n)
    (is_ebit(pos_r) && !$past(cfg_l.transmit_sync_mux_control.fas_src) && $past(cfg_l.transmit_sync_mux_control.ebit_src) == 2'h0)
      |-> (data_r == ($past(pend_r) == 2'h0)))
    else $error("e-bit does not follow pending crc errors");
  chk_ebit_force_zero: assert property (@(posedge tx_serial_clock) disable iff (!lrst_n)
    (is_ebit(pos_r) && !$past(cfg_l.transmit_sync_mux_control.fas_src) && $past(cfg_l.transmit_sync_mux_control.ebit_src) == 2'h1)
      |-> !data_r)
    else $error("forced-zero e-bit sent as one");
  chk_ebit_force_one: assert property (@(posedge tx_serial_clock) disable iff (!lrst_n)
    (is_ebit(pos_r) && !$past(cfg_l.transmit_sync_mux_control.fas_src) && $past(cfg_l.transmit_sync_mux_control.ebit_src) == 2'h2)
      |-> data_r)
    else $error("forced-one e-bit sent as zero");
  chk_ebit_link_data: assert property (@(posedge tx_serial_clock) disable iff (!lrst_n)
    (is_ebit(pos_r) && !$past(cfg_l.transmit_sync_mux_control.fas_src) && $past(cfg_l.transmit_sync_mux_control.ebit_src) == 2'h3)
      |-> data_r == $past(ser_s))
    else $error("data-link e-bit differs from serial input");
  chk_ts0_passthru: assert property (@(posedge tx_serial_clock) disable iff (!lrst_n)
    (is_ts0(pos_r) && $past(cfg_l.transmit_sync_mux_control.fas_src)) |-> data_r == $past(ser_s))
    else $error("external overhead not passed through");
  chk_frame_restart: assert property (@(posedge tx_serial_clock) disable iff (!lrst_n)
    (ext_l && fr_s && !mf_s) |=> (pos_r.bit_no == 8'h00 && fr_o_r))
    else $error("frame sync did not restart the frame");
  chk_mframe_restart: assert property (@(posedge tx_serial_clock) disable iff (!lrst_n)
    (ext_l && mf_s) |=> (pos_r == '0 && mf_o_r))
    else $error("multiframe sync did not restart the multiframe");
  chk_pin_direction: assert property (@(posedge tx_serial_clock) disable iff (!lrst_n)
    (ext_l [*2]) |-> (tx_frame_boundary_pin_oe_n && tx_multiframe_boundary_pin_oe_n))
    else $error("sync pins driven under system control");
endmodule : tos_tx_overhead_select
`default_nettype wire

// file: tos_regs.svh
// register offsets, field values and framing constants of the overhead selector
`ifndef TOS_REGS_SVH
`define TOS_REGS_SVH

`define TOS_AXI_AW        12
`define TOS_OFF_SMR       12'h000
`define TOS_OFF_CSS       12'h004
`define TOS_OFF_STAT      12'h008
`define TOS_OFF_MFCNT     12'h00c

`define TOS_SMR_RST       8'h00
`define TOS_SMR_WMASK     8'hdf
`define TOS_CSS_RST       2'h0
`define TOS_CSS_TX_SERIAL_CLOCK  2'h1

`define TOS_EBIT_CRC      2'h0
`define TOS_EBIT_ZERO     2'h1
`define TOS_EBIT_ONE      2'h2
`define TOS_EBIT_LINK     2'h3

`define TOS_FAW           7'h1b
`define TOS_MFAW          6'h0b
`define TOS_A_BIT         1'h0
`define TOS_TS0_SLOT      5'h00
`define TOS_TS0_SI        8'h00
`define TOS_LAST_BIT      8'hff
`define TOS_SMF_LAST      3'h7
`define TOS_EBIT_FRAME_A  4'hd
`define TOS_EBIT_FRAME_B  4'hf
`define TOS_PEND_MAX      2'h3

`define TOS_RESP_OKAY     2'h0
`define TOS_RESP_SLVERR   2'h2

`endif

// file: tos_pkg.sv
// shared types of the overhead selector
`default_nettype none
package tos_pkg;

  typedef struct packed {
    logic [1:0] ebit_src;
    logic       rsvd;
    logic       sync_sel;
    logic [1:0] dl_src;
    logic       crc_src;
    logic       fas_src;
  } tos_smr_type;

  typedef struct packed {
    logic        err_tgl;
    logic [1:0]  tx_clock_source_field;
    tos_smr_type transmit_sync_mux_control;
  } tos_xcfg_type;

  typedef struct packed {
    logic [3:0] frame;
    logic [7:0] bit_no;
  } tos_pos_type;

  typedef enum logic [1:0] {
    LS_IDLE   = 2'h0,
    LS_FREE   = 2'h1,
    LS_SLAVED = 2'h3
  } tos_ls_type;

endpackage : tos_pkg
`default_nettype wire

// file: tos_sync_bus.sv
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none
module tos_sync_bus #(
  parameter int W = 1
) (
  // destination clock and synchronous reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // level in, synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;
endmodule : tos_sync_bus
`default_nettype wire

// file: tos_axil_slave.sv
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/1ps
`default_nettype none
`include "tos_regs.svh"
module tos_axil_slave #(
  parameter int AW = 12
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // write channels
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // read channels
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // register side
  output logic               reg_wr,
  output logic [AW-1:0]      reg_waddr,
  output logic [31:0]        reg_wdata,
  output logic [3:0]         reg_wstrb,
  input  wire logic          reg_wok,
  output logic [AW-1:0]      reg_raddr,
  input  wire logic [31:0]   reg_rdata,
  input  wire logic          reg_rok
);
  logic          aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [AW-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]   wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0]    wstrb_r, wstrb_nxt;
  logic          bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]    bresp_r, bresp_nxt, rresp_r, rresp_nxt;

  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready  = !w_full_r;
  assign s_axi_arready = !rvalid_r;
  assign reg_wr        = aw_full_r && w_full_r && !bvalid_r;
  assign reg_waddr     = awaddr_r;
  assign reg_wdata     = wdata_r;
  assign reg_wstrb     = wstrb_r;
  assign reg_raddr     = s_axi_araddr;

  // address and data are held separately, so either may come first
  always_comb begin
    aw_full_nxt = aw_full_r;
    awaddr_nxt  = awaddr_r;
    w_full_nxt  = w_full_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_awvalid && !aw_full_r) begin
      aw_full_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_r) begin
      w_full_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (reg_wr) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = reg_wok ? `TOS_RESP_OKAY : `TOS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = reg_rok ? reg_rdata : 32'h0000_0000;
      rresp_nxt  = reg_rok ? `TOS_RESP_OKAY : `TOS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      awaddr_r  <= '0;
      w_full_r  <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `TOS_RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `TOS_RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      awaddr_r  <= awaddr_nxt;
      w_full_r  <= w_full_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;
endmodule : tos_axil_slave
`default_nettype wire

// file: tos_sys_model.sv
// system-side equipment: serial data and sync pulses on the link clock
`timescale 1ns/1ps
`default_nettype none
module tos_sys_model (
  // link clock
  input  wire logic clk,
  // bench requests
  input  wire logic ser_lvl,
  input  wire logic fs_req,
  input  wire logic mfs_req,
  // toward the framer pins
  output logic      ser,
  output logic      fs,
  output logic      mfs
);
  initial begin
    ser = 1'b1;
    fs  = 1'b0;
    mfs = 1'b0;
  end
  // one-cycle pulses mark the boundaries; the bench resolves who owns the pin
  always @(posedge clk) begin
    ser <= ser_lvl;
    fs  <= fs_req;
    mfs <= mfs_req;
  end
endmodule : tos_sys_model
`default_nettype wire

// file: e1_tx_overhead_source_select_test.sv
// testbench of the e1 transmit overhead selector
`timescale 1ns/1ps
`default_nettype none
`include "tos_regs.svh"
module e1_tx_overhead_source_select_test;
  import tos_pkg::*;
  logic        aclk, lclk;
  logic        aresetn = 1'b0;
  logic        err     = 1'b0;
  logic [11:0] addr    = 12'h000;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        ser_lvl = 1'b1, fs_req = 1'b0, mfs_req = 1'b0;
  wire  logic  awready, wready, bvalid, arready, rvalid, line;
  wire  logic  fo, foe, mo, moe, mser, mfs, mmfs;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata;
  int          mismatches = 0, check_count = 0, lcyc = 0, e0 = 0;
  logic [31:0] rd;
  logic [1:0]  rs;

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    lclk = 1'b0;
    #3.7;
    forever #6 lclk = ~lclk;
  end
  always @(posedge lclk) lcyc <= lcyc + 1;

  tos_tx_overhead_select uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(addr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(addr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_smf_crc_err(err), .tx_serial_clock(lclk), .tx_serial_input_ch(mser),
    .tx_frame_boundary_pin_i(foe ? mfs : fo), .tx_frame_boundary_pin_o(fo),
    .tx_frame_boundary_pin_oe_n(foe),
    .tx_multiframe_boundary_pin_i(moe ? mmfs : mo), .tx_multiframe_boundary_pin_o(mo),
    .tx_multiframe_boundary_pin_oe_n(moe), .tx_line_data(line)
  );
  tos_sys_model sys (
    .clk(lclk), .ser_lvl(ser_lvl), .fs_req(fs_req), .mfs_req(mfs_req),
    .ser(mser), .fs(mfs), .mfs(mmfs)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; the master never assumes a latency, it waits for the response handshake or the 100-cycle bound
  task automatic axi(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    addr    <= a;
    wdata   <= d;
    awvalid <= w;
    wvalid  <= w;
    bready  <= w;
    arvalid <= !w;
    rready  <= !w;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      n++;
      if (n > 100) begin
        mismatches++;
        $display("BAD %0t bus timeout", $time);
        stop_test();
      end
    end while (!(bready && bvalid) && !(rready && rvalid));
    rd = rdata;
    rs = w ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
  endtask : axi

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    axi(1'b1, a, d);
    chk(rs, `TOS_RESP_OKAY);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    axi(1'b0, a, 32'h0000_0000);
    chk(rs, `TOS_RESP_OKAY);
    chk(rd, exp);
  endtask : rdc

  task automatic lwait(input int n);
    repeat (n) @(posedge lclk);
  endtask : lwait

  // pulse a sync pin; e0 + 1 marks the link edge after which the pin is high
  task automatic sync(input logic mf);
    @(posedge lclk);
    fs_req  <= !mf;
    mfs_req <= mf;
    @(posedge lclk);
    fs_req  <= 1'b0;
    mfs_req <= 1'b0;
    e0 = lcyc;
  endtask : sync

  // line bit at stream position p, three link edges after the pin
  task automatic look(input int p, input logic exp);
    for (int n = 0; n < 5000 && lcyc < e0 + p + 4; n++) begin
      @(posedge lclk);
      #1;
    end
    if (lcyc < e0 + p + 4) begin
      mismatches++;
      $display("BAD %0t link timeout", $time);
      stop_test();
    end
    chk(line, exp);
  endtask : look

  task automatic mode(input logic [7:0] s, input logic sv);
    wr(`TOS_OFF_SMR, {24'h00_0000, s});
    ser_lvl <= sv;
    lwait(8);
    sync(1'b1);
  endtask : mode

  task automatic t_regs;
    rdc(`TOS_OFF_SMR, 32'h0000_0000);
    rdc(`TOS_OFF_CSS, 32'h0000_0000);
    wr(`TOS_OFF_SMR, 32'h0000_00ff);
    rdc(`TOS_OFF_SMR, 32'h0000_00df);
    axi(1'b1, 12'h010, 32'h0000_0001);
    chk(rs, `TOS_RESP_SLVERR);
    axi(1'b0, 12'h010, 32'h0000_0000);
    chk(rs, `TOS_RESP_SLVERR);
  endtask : t_regs

  task automatic t_emodes;
    wr(`TOS_OFF_CSS, 32'h0000_0001);
    mode(8'h40, 1'b1);
    chk(foe & moe, 1'b1);
    rdc(`TOS_OFF_STAT, 32'h0000_0007);
    look(13 * 256, 1'b0);
    look(15 * 256, 1'b0);
    mode(8'h80, 1'b0);
    look(3, 1'b1);
    look(13 * 256, 1'b1);
    mode(8'hc0, 1'b1);
    look(13 * 256, 1'b1);
    ser_lvl <= 1'b0;
    look(15 * 256, 1'b0);
    mode(8'h81, 1'b0);
    look(3, 1'b0);
    look(13 * 256, 1'b0);
  endtask : t_emodes

  task automatic t_crc;
    mode(8'h00, 1'b0);
    @(posedge aclk);
    err <= 1'b1;
    @(posedge aclk);
    err <= 1'b0;
    look(13 * 256, 1'b0);
    look(15 * 256, 1'b1);
  endtask : t_crc

  // frame sync mid-frame: odd frame 1 starts there
  task automatic t_fsync;
    sync(1'b1);
    lwait(40);
    sync(1'b0);
    look(1, 1'b1);
    look(3, 1'b0);
  endtask : t_fsync

  task automatic t_outputs;
    wr(`TOS_OFF_SMR, 32'h0000_0010);
    lwait(8);
    #1;
    chk(foe | moe, 1'b0);
    // pulses last one link cycle: look just after the edge that launches them
    for (int n = 0; n < 600 && fo !== 1'b1; n++) begin
      @(posedge lclk);
      #1;
    end
    chk(fo, 1'b1);
    for (int n = 0; n < 4200 && mo !== 1'b1; n++) begin
      @(posedge lclk);
      #1;
    end
    chk(mo & fo, 1'b1);
  endtask : t_outputs

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    lwait(6);
    t_regs();
    t_emodes();
    t_crc();
    t_fsync();
    t_outputs();
    stop_test();
  end
endmodule : e1_tx_overhead_source_select_test
`default_nettype wire
